//--- verilog/ama_pkg.sv
`default_nettype none
package ama_pkg;

  // Machine cycle and instruction lengths in time states
  localparam logic [2:0] FETCH_STATES = 3'h5;
  localparam logic [2:0] READ_STATES = 3'h3;
  localparam logic [4:0] INSTR_STATES = 5'h8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STAT_OFS = 8'h04;
  localparam logic [7:0] REG_ACC_OFS = 8'h08;
  localparam logic [7:0] REG_FLAG_OFS = 8'h0C;
  localparam logic [7:0] REG_PTR_OFS = 8'h10;
  localparam logic [7:0] REG_PC_OFS = 8'h14;
  localparam int REG_COUNT = 6;

  // Field positions
  localparam int CTRL_STEP_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BAD_BIT = 1;
  localparam int STAT_OPC_LSB = 8;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_Z_BIT = 1;
  localparam int FLAG_S_BIT = 2;
  localparam int FLAG_P_BIT = 3;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;

  // Opcode groups: top two bits and low three bits
  localparam logic [1:0] MEM_GRP_HI = 2'h2;
  localparam logic [2:0] MEM_GRP_LO = 3'h7;
  localparam logic [1:0] IMM_GRP_HI = 2'h0;
  localparam logic [2:0] IMM_GRP_LO = 3'h4;

  // Operation field, opcode bits 5..3
  typedef enum logic [2:0] {
    FN_ADD = 3'h0,
    FN_ADC = 3'h1,
    FN_SUB = 3'h2,
    FN_SBB = 3'h3,
    FN_AND = 3'h4,
    FN_XOR = 3'h5,
    FN_OR = 3'h6,
    FN_CMP = 3'h7
  } ama_fn_t;

endpackage
`default_nettype wire

//--- verilog/ama_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ama_alu_if import ama_pkg::*; ();
  ama_fn_t fn;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] res;
  logic c;
  logic z;
  logic s;
  logic p;
  logic wr_acc;

  modport core (output fn, output a, output b, output cin,
    input res, input c, input z, input s, input p, input wr_acc);
  modport alu (input fn, input a, input b, input cin,
    output res, output c, output z, output s, output p, output wr_acc);
endinterface
`default_nettype wire

//--- verilog/ama_alu.sv
`timescale 1ns/1ps
`default_nettype none
module ama_alu
  import ama_pkg::*;
(
  // Operands and results
  ama_alu_if.alu bus
);
  logic [8:0] wide;
  logic use_c;

  always_comb
  begin
    use_c = (bus.fn == FN_ADC) || (bus.fn == FN_SBB);
    unique case (bus.fn)
      FN_ADD, FN_ADC:
      begin
        wide = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin & use_c}; // RQ4
      end
      FN_SUB, FN_SBB, FN_CMP:
      begin
        // Bit 8 is the borrow of the two's complement difference
        wide = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin & use_c}; // RQ6
      end
      FN_AND:
      begin
        wide = {1'b0, bus.a & bus.b}; // RQ7
      end
      FN_XOR:
      begin
        wide = {1'b0, bus.a ^ bus.b}; // RQ8
      end
      FN_OR:
      begin
        wide = {1'b0, bus.a | bus.b}; // RQ9
      end
    endcase
    bus.res = wide[7:0];
    bus.c = wide[8]; // RQ17 RQ19
    bus.z = (wide[7:0] == 8'h00); // RQ11
    bus.s = wide[7]; // RQ18
    bus.p = ~^wide[7:0]; // RQ12
    bus.wr_acc = (bus.fn != FN_CMP); // RQ10
  end
endmodule
`default_nettype wire

//--- verilog/ama_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ama_wb_slave
  import ama_pkg::*;
#(
  parameter int NREG = REG_COUNT
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register file side
  input wire logic [NREG-1:0][31:0] rd_words_i,
  output logic wr_o,
  output logic [5:0] wr_idx_o,
  output logic [31:0] wr_dat_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ama_wb_t;

  ama_wb_t cur_ff;
  ama_wb_t nxt_st;
  logic req;
  logic mapped;
  logic [31:0] cur_word;
  logic [31:0] lane_mask;

  // Gap after ack keeps one access from being taken twice
  assign req = wb_cyc_i && wb_stb_i && !cur_ff.ack;
  assign wr_idx_o = wb_adr_i[7:2];
  assign mapped = (wr_idx_o < 6'(NREG));
  assign cur_word = mapped ? rd_words_i[wr_idx_o] : 32'h00000000;

  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign lane_mask[8*g +: 8] = {8{wb_sel_i[g]}};
  end

  // Unselected lanes keep their value
  assign wr_dat_o = (cur_word & ~lane_mask) | (wb_dat_i & lane_mask);
  assign wr_o = req && wb_we_i && mapped;
  assign wb_ack_o = cur_ff.ack;
  assign wb_dat_o = cur_ff.dat;

  always_comb
  begin
    nxt_st.ack = req;
    nxt_st.dat = (req && !wb_we_i) ? cur_word : 32'h00000000;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cur_ff <= '0;
    else
      cur_ff <= nxt_st;
  end
endmodule
`default_nettype wire

//--- verilog/ama_accum_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1 - Memory operand read at pointer pair, never written
// RQ2 - Memory ops: one byte, fetch then read, 8
// RQ3 - Memory add loads accumulator with sum
// RQ4 - Memory add with carry adds carry too
// RQ5 - Memory subtract loads two's complement difference
// RQ6 - Memory subtract with borrow also subtracts carry
// RQ7 - Memory AND replaces accumulator
// RQ8 - Memory XOR replaces accumulator
// RQ9 - Memory OR replaces accumulator
// RQ10 - Compare keeps accumulator; carry when operand larger
// RQ11 - Compare sets zero when operands equal
// RQ12 - Compare sign, parity from discarded difference
// RQ13 - Immediate ops: two bytes, 8 states, byte kept
// RQ14 - Immediate add stores sum in accumulator
// RQ15 - Immediate add with carry adds carry too
// RQ16 - Immediate subtract stores two's complement difference
// RQ17 - Carry on carry or borrow; zero on zero
// RQ18 - Sign is bit 7; parity one when even
// RQ19 - AND, XOR, OR always clear carry
// RQ20 - Immediate byte at next address; pc skips it
module ama_accum_alu
  import ama_pkg::*;
#(
  parameter int TS_DIV = 1
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Memory read port, same clock domain
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  // Status
  output logic [7:0] acc_o,
  output logic [3:0] flags_o,
  output logic busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FETCH = 3'h2,
    ST_READ = 3'h4
  } ama_seq_t;

  typedef struct packed {
    ama_seq_t st;
    logic [7:0] div;
    logic [2:0] ts;
    logic [4:0] tcnt;
    logic got;
    logic rd;
    logic [15:0] addr;
    logic [7:0] opc;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic [3:0] flg;
    logic [7:0] hreg;
    logic [7:0] lreg;
    logic [15:0] pc;
    logic run;
    logic bad;
    logic bsy;
  } ama_core_t;

  localparam logic [7:0] DIV_LAST = 8'(TS_DIV - 1);

  ama_core_t cur_ff;
  ama_core_t nxt_st;
  ama_alu_if alu_bus ();

  logic busy;
  logic tick;
  logic [2:0] ts_last;
  logic cyc_done;
  logic fin_fetch;
  logic fin_read;
  logic is_mem;
  logic is_imm;
  logic sw_wr;
  logic [5:0] sw_idx;
  logic [31:0] sw_dat;
  logic [REG_COUNT-1:0][31:0] rd_words;

  ama_wb_slave #(
    .NREG(REG_COUNT)
  ) u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rd_words_i(rd_words),
    .wr_o(sw_wr),
    .wr_idx_o(sw_idx),
    .wr_dat_o(sw_dat)
  );

  ama_alu u_alu (
    .bus(alu_bus.alu)
  );

  assign alu_bus.fn = ama_fn_t'(cur_ff.opc[5:3]);
  assign alu_bus.a = cur_ff.acc;
  assign alu_bus.b = cur_ff.opnd;
  assign alu_bus.cin = cur_ff.flg[FLAG_C_BIT];

  assign rd_words[REG_CTRL_OFS[7:2]] = {30'h00000000, cur_ff.run, 1'b0};
  assign rd_words[REG_STAT_OFS[7:2]] = {16'h0000, cur_ff.opc, 6'h00, cur_ff.bad, busy};
  assign rd_words[REG_ACC_OFS[7:2]] = {24'h000000, cur_ff.acc};
  assign rd_words[REG_FLAG_OFS[7:2]] = {28'h0000000, cur_ff.flg};
  assign rd_words[REG_PTR_OFS[7:2]] = {16'h0000, cur_ff.hreg, cur_ff.lreg};
  assign rd_words[REG_PC_OFS[7:2]] = {16'h0000, cur_ff.pc};

  // Busy kept in its own flop so busy_o leaves a register
  assign busy = cur_ff.bsy;
  assign tick = busy && (cur_ff.div == DIV_LAST);
  assign ts_last = (cur_ff.st == ST_FETCH) ? FETCH_STATES - 3'h1 : READ_STATES - 3'h1;
  // A slow memory stretches the last time state until its byte is in
  assign cyc_done = tick && (cur_ff.ts == ts_last) && cur_ff.got;
  assign fin_fetch = cyc_done && (cur_ff.st == ST_FETCH);
  assign fin_read = cyc_done && (cur_ff.st == ST_READ);
  assign is_mem = (cur_ff.opc[7:6] == MEM_GRP_HI) && (cur_ff.opc[2:0] == MEM_GRP_LO);
  assign is_imm = (cur_ff.opc[7:6] == IMM_GRP_HI) && (cur_ff.opc[2:0] == IMM_GRP_LO)
    && (cur_ff.opc[5:3] <= FN_SUB);

  always_comb
  begin
    nxt_st = cur_ff;
    if (busy)
    begin
      nxt_st.div = tick ? 8'h00 : cur_ff.div + 8'h01;
      // Stretch ticks are waits, not time states
      nxt_st.tcnt = (tick && (cur_ff.ts != ts_last || cur_ff.got)) ? cur_ff.tcnt + 5'h01
        : cur_ff.tcnt;
    end
    // Datapath registers are locked while an instruction runs
    if (sw_wr && (sw_idx == REG_CTRL_OFS[7:2]))
      nxt_st.run = sw_dat[CTRL_RUN_BIT];
    if (sw_wr && !busy)
    begin
      unique case (sw_idx)
        REG_ACC_OFS[7:2]: nxt_st.acc = sw_dat[7:0];
        REG_FLAG_OFS[7:2]: nxt_st.flg = sw_dat[3:0];
        REG_PTR_OFS[7:2]:
        begin
          nxt_st.hreg = sw_dat[15:8];
          nxt_st.lreg = sw_dat[7:0];
        end
        REG_PC_OFS[7:2]: nxt_st.pc = sw_dat[15:0];
        default: nxt_st.run = nxt_st.run;
      endcase
    end
    unique case (cur_ff.st)
      ST_IDLE:
      begin
        if (cur_ff.run || (sw_wr && (sw_idx == REG_CTRL_OFS[7:2])
          && sw_dat[CTRL_STEP_BIT]))
        begin
          nxt_st.st = ST_FETCH;
          nxt_st.addr = nxt_st.pc;
          nxt_st.rd = 1'b1;
          nxt_st.got = 1'b0;
          nxt_st.ts = 3'h0;
          nxt_st.div = 8'h00;
          nxt_st.tcnt = 5'h00;
          nxt_st.bad = 1'b0;
        end
      end
      ST_FETCH, ST_READ:
      begin
        // Acks outside an open request are ignored
        if (cur_ff.rd && mem_ack_i)
        begin
          nxt_st.rd = 1'b0;
          nxt_st.got = 1'b1;
          if (cur_ff.st == ST_FETCH)
            nxt_st.opc = mem_rdata_i;
          else
            nxt_st.opnd = mem_rdata_i;
        end
        if (tick && (cur_ff.ts != ts_last))
          nxt_st.ts = cur_ff.ts + 3'h1;
        if (fin_fetch)
        begin
          nxt_st.ts = 3'h0;
          nxt_st.got = 1'b0;
          nxt_st.pc = cur_ff.pc + 16'h0001;
          if (is_mem)
          begin
            nxt_st.st = ST_READ; // RQ2
            nxt_st.addr = {cur_ff.hreg, cur_ff.lreg}; // RQ1
            nxt_st.rd = 1'b1;
          end
          else if (is_imm)
          begin
            nxt_st.st = ST_READ; // RQ13
            nxt_st.addr = cur_ff.pc + 16'h0001; // RQ20
            nxt_st.rd = 1'b1;
          end
          else
          begin
            // Other opcodes are not executed here
            nxt_st.st = ST_IDLE;
            nxt_st.bad = 1'b1;
          end
        end
        if (fin_read)
        begin
          nxt_st.st = ST_IDLE;
          nxt_st.ts = 3'h0;
          nxt_st.got = 1'b0;
          if (alu_bus.wr_acc)
            nxt_st.acc = alu_bus.res; // RQ3 RQ5 RQ14 RQ15 RQ16
          nxt_st.flg[FLAG_C_BIT] = alu_bus.c; // RQ17
          nxt_st.flg[FLAG_Z_BIT] = alu_bus.z;
          nxt_st.flg[FLAG_S_BIT] = alu_bus.s; // RQ18
          nxt_st.flg[FLAG_P_BIT] = alu_bus.p;
          if (is_imm)
            nxt_st.pc = cur_ff.pc + 16'h0001; // RQ20
        end
      end
      default:
      begin
        nxt_st.st = ST_IDLE;
        nxt_st.rd = 1'b0;
      end
    endcase
    nxt_st.bsy = (nxt_st.st != ST_IDLE);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_ff <= '0;
      cur_ff.st <= ST_IDLE;
      cur_ff.acc <= ACC_RST;
      cur_ff.flg <= FLAG_RST;
      cur_ff.hreg <= PTR_RST[15:8];
      cur_ff.lreg <= PTR_RST[7:0];
      cur_ff.pc <= PC_RST;
    end
    else
      cur_ff <= nxt_st;
  end

  assign mem_addr_o = cur_ff.addr;
  assign mem_rd_o = cur_ff.rd;
  assign acc_o = cur_ff.acc;
  assign flags_o = cur_ff.flg;
  assign busy_o = busy;

  logic [8:0] add9;
  logic [7:0] diff8;
  assign add9 = {1'b0, cur_ff.acc} + {1'b0, cur_ff.opnd};
  assign diff8 = cur_ff.acc - cur_ff.opnd;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_MEM_ADDR: assert property ( // RQ1
    (cur_ff.st == ST_READ) && is_mem |-> mem_addr_o == {cur_ff.hreg, cur_ff.lreg})
    else $error("memory operand not read at pointer pair");
  AST_EIGHT_STATES: assert property ( // RQ2
    fin_read |-> cur_ff.tcnt + 5'h01 == INSTR_STATES)
    else $error("instruction did not take eight time states");
  AST_ADD: assert property ( // RQ3
    fin_read && alu_bus.fn == FN_ADD |=> acc_o == $past(add9[7:0]))
    else $error("add result wrong");
  AST_ADC: assert property ( // RQ4
    fin_read && alu_bus.fn == FN_ADC
    |=> acc_o == $past(add9[7:0]) + {7'h00, $past(cur_ff.flg[FLAG_C_BIT])})
    else $error("add with carry result wrong");
  AST_SUB: assert property ( // RQ5
    fin_read && alu_bus.fn == FN_SUB |=> acc_o == $past(diff8)
    && flags_o[FLAG_C_BIT] == ($past(cur_ff.opnd) > $past(cur_ff.acc)))
    else $error("subtract result or borrow wrong");
  AST_SBB: assert property ( // RQ6
    fin_read && alu_bus.fn == FN_SBB
    |=> acc_o == $past(diff8) - {7'h00, $past(cur_ff.flg[FLAG_C_BIT])})
    else $error("subtract with borrow result wrong");
  AST_AND: assert property ( // RQ7
    fin_read && alu_bus.fn == FN_AND |=> acc_o == ($past(cur_ff.acc) & $past(cur_ff.opnd)))
    else $error("and result wrong");
  AST_XOR: assert property ( // RQ8
    fin_read && alu_bus.fn == FN_XOR |=> acc_o == ($past(cur_ff.acc) ^ $past(cur_ff.opnd)))
    else $error("xor result wrong");
  AST_OR: assert property ( // RQ9
    fin_read && alu_bus.fn == FN_OR |=> acc_o == ($past(cur_ff.acc) | $past(cur_ff.opnd)))
    else $error("or result wrong");
  AST_CMP_KEEP: assert property ( // RQ10
    fin_read && alu_bus.fn == FN_CMP |=> acc_o == $past(acc_o)
    && flags_o[FLAG_C_BIT] == ($past(cur_ff.opnd) > $past(cur_ff.acc)))
    else $error("compare changed accumulator or carry wrong");
  AST_CMP_ZERO: assert property ( // RQ11
    fin_read && alu_bus.fn == FN_CMP
    |=> flags_o[FLAG_Z_BIT] == ($past(cur_ff.opnd) == $past(cur_ff.acc)))
    else $error("compare zero flag wrong");
  AST_CMP_SP: assert property ( // RQ12
    fin_read && alu_bus.fn == FN_CMP |=> flags_o[FLAG_S_BIT] == $past(diff8[7])
    && flags_o[FLAG_P_BIT] == ~^$past(diff8))
    else $error("compare sign or parity wrong");
  AST_IMM_ADDR: assert property ( // RQ13
    fin_fetch && is_imm |=> mem_rd_o && mem_addr_o == cur_ff.pc)
    else $error("immediate byte not read after opcode");
  AST_ADD_FLAGS: assert property ( // RQ17
    fin_read && alu_bus.fn == FN_ADD |=> flags_o[FLAG_C_BIT] == $past(add9[8])
    && flags_o[FLAG_Z_BIT] == (acc_o == 8'h00))
    else $error("add carry or zero flag wrong");
  AST_SIGN_PAR: assert property ( // RQ18
    fin_read && alu_bus.fn != FN_CMP
    |=> flags_o[FLAG_S_BIT] == acc_o[7] && flags_o[FLAG_P_BIT] == ~^acc_o)
    else $error("sign or parity flag wrong");
  AST_LOGIC_C: assert property ( // RQ19
    fin_read && (alu_bus.fn == FN_AND || alu_bus.fn == FN_XOR || alu_bus.fn == FN_OR)
    |=> !flags_o[FLAG_C_BIT])
    else $error("logic operation left carry set");
  AST_IMM_PC: assert property ( // RQ20
    fin_read && is_imm |=> cur_ff.pc == $past(cur_ff.addr) + 16'h0001)
    else $error("pc not advanced past immediate byte");

  COV_MEM_OP: cover property (fin_read && is_mem);
  COV_IMM_OP: cover property (fin_read && is_imm);
  COV_BAD_OP: cover property (fin_fetch && !is_mem && !is_imm);
  COV_CMP_EQ: cover property (fin_read && alu_bus.fn == FN_CMP && diff8 == 8'h00);
endmodule
`default_nettype wire

//--- testbench/ama_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ama_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Read port, no write port at all
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_rd_i,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] last_addr;
  int lat = 0;
  int wait_ff;

  // Answer after lat idle cycles; data toggles when not answering
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_ack_o <= 1'h0;
      mem_rdata_o <= 8'h5A;
      wait_ff <= 0;
      last_addr <= 16'h0000;
    end
    else if (mem_rd_i && !mem_ack_o && wait_ff >= lat)
    begin
      mem_ack_o <= 1'h1;
      mem_rdata_o <= mem[mem_addr_i];
      last_addr <= mem_addr_i;
      wait_ff <= 0;
    end
    else
    begin
      mem_ack_o <= 1'h0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_ff <= (mem_rd_i && !mem_ack_o) ? wait_ff + 1 : 0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ama_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] mem_addr_o;
  logic mem_rd_o, mem_ack_i, busy_o;
  logic [7:0] mem_rdata_i, acc_o;
  logic [3:0] flags_o;
  int mismatches = 0;
  int n_checks = 0;
  int busy_n = 0;

  ama_accum_alu #(.TS_DIV(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .acc_o(acc_o),
    .flags_o(flags_o), .busy_o(busy_o));
  ama_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_addr_i(mem_addr_o),
    .mem_rd_i(mem_rd_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  initial
  begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Busy counted mid-cycle, where it is settled, never by the design itself
  always @(negedge clk_i)
    if (busy_o === 1'h1)
      busy_n <= busy_n + 1;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic to_fail;
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    end_sim();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    // Ack looked at mid-cycle; the edge ending that cycle is the ack edge
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 50);
    if (wb_ack_o !== 1'h1)
      to_fail();
    rd = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'h1, adr, dat, d);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'h0, adr, 32'h0000_0000, d);
    chk(d, exp);
  endtask

  // Reference result {acc, P, S, Z, C}
  function automatic logic [11:0] ref_op(input logic [2:0] fn, input logic [7:0] a,
    input logic [7:0] b, input logic cin);
    logic [8:0] t;
    logic [7:0] r;
    case (fn)
      3'h0: t = {1'h0, a} + {1'h0, b};
      3'h1: t = {1'h0, a} + {1'h0, b} + {8'h00, cin};
      3'h2, 3'h7: t = {1'h0, a} - {1'h0, b};
      3'h3: t = {1'h0, a} - {1'h0, b} - {8'h00, cin};
      3'h4: t = {1'h0, a & b};
      3'h5: t = {1'h0, a ^ b};
      default: t = {1'h0, a | b};
    endcase
    r = t[7:0];
    return {(fn == 3'h7) ? a : r, ~^r, r[7], r == 8'h00, t[8]};
  endfunction

  task automatic wait_idle;
    int k;
    k = 0;
    do
    begin
      @(negedge clk_i);
      k++;
    end
    while (busy_o === 1'h1 && k < 500);
    if (busy_o !== 1'h0)
      to_fail();
  endtask

  task automatic start_and_wait;
    wr(REG_CTRL_OFS, 32'h0000_0001);
    wait_idle();
  endtask

  // One instruction from pc 0x0100; memory operand at pointer 0x2345
  task automatic run_op(input logic imm, input logic [2:0] fn, input logic [7:0] a,
    input logic [7:0] b, input logic cin, input int lat);
    logic [15:0] oa;
    logic [11:0] e;
    int n0;
    oa = imm ? 16'h0101 : 16'h2345;
    u_mem.mem[16'h0100] = imm ? {2'h0, fn, 3'h4} : {2'h2, fn, 3'h7};
    u_mem.mem[oa] = b;
    u_mem.lat = lat;
    wr(REG_PC_OFS, 32'h0000_0100);
    wr(REG_PTR_OFS, 32'h0000_2345);
    wr(REG_ACC_OFS, {24'h00_0000, a});
    wr(REG_FLAG_OFS, {31'h0000_0000, cin});
    e = ref_op(fn, a, b, cin);
    n0 = busy_n;
    start_and_wait();
    chk({24'h00_0000, acc_o}, {24'h00_0000, e[11:4]});
    chk({28'h000_0000, flags_o}, {28'h000_0000, e[3:0]});
    chk({16'h0000, u_mem.last_addr}, {16'h0000, oa});
    chk({16'h0000, u_mem.mem[oa]}, {16'h0000, 8'h00, b});
    rd_chk(REG_PC_OFS, imm ? 32'h0000_0102 : 32'h0000_0101);
    if (lat == 0)
      chk(32'(busy_n - n0), 32'h0000_0008);
    else
      chk({31'h0000_0000, (busy_n - n0) > 8}, 32'h0000_0001);
  endtask

  initial
  begin
    rst_i = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk({23'h00_0000, busy_o, acc_o}, 32'h0000_0000);
    chk({28'h000_0000, flags_o}, 32'h0000_0000);
    rd_chk(REG_PC_OFS, 32'h0000_0000);
    rd_chk(REG_STAT_OFS, 32'h0000_0000);
    run_op(1'h0, 3'h0, 8'hFF, 8'h01, 1'h0, 0);
    run_op(1'h0, 3'h1, 8'h7F, 8'h00, 1'h1, 0);
    run_op(1'h0, 3'h2, 8'h10, 8'h20, 1'h0, 0);
    run_op(1'h0, 3'h3, 8'h00, 8'h00, 1'h1, 0);
    run_op(1'h0, 3'h4, 8'hF0, 8'h3C, 1'h1, 0);
    run_op(1'h0, 3'h5, 8'hA5, 8'hA5, 1'h1, 0);
    run_op(1'h0, 3'h6, 8'h81, 8'h02, 1'h1, 0);
    run_op(1'h0, 3'h7, 8'h05, 8'h06, 1'h0, 0);
    run_op(1'h0, 3'h7, 8'h42, 8'h42, 1'h1, 0);
    run_op(1'h1, 3'h0, 8'h80, 8'h80, 1'h0, 0);
    run_op(1'h1, 3'h1, 8'h01, 8'hFE, 1'h1, 0);
    run_op(1'h1, 3'h2, 8'h03, 8'h01, 1'h1, 0);
    run_op(1'h0, 3'h1, 8'h3C, 8'hC3, 1'h1, 3);
    run_op(1'h1, 3'h2, 8'h00, 8'h01, 1'h0, 2);
    // Unhandled opcode: fetch only, operand never read
    u_mem.lat = 0;
    u_mem.mem[16'h0100] = 8'h00;
    wr(REG_PC_OFS, 32'h0000_0100);
    start_and_wait();
    rd_chk(REG_STAT_OFS, 32'h0000_0002);
    rd_chk(REG_PC_OFS, 32'h0000_0101);
    chk({16'h0000, u_mem.last_addr}, 32'h0000_0100);
    // Run mode: two immediate adds back to back, then run cleared
    u_mem.mem[16'h0100] = 8'h04;
    u_mem.mem[16'h0101] = 8'h01;
    u_mem.mem[16'h0102] = 8'h04;
    u_mem.mem[16'h0103] = 8'h02;
    wr(REG_PC_OFS, 32'h0000_0100);
    wr(REG_ACC_OFS, 32'h0000_0010);
    wr(REG_CTRL_OFS, 32'h0000_0002);
    repeat (12) @(posedge clk_i);
    wr(REG_CTRL_OFS, 32'h0000_0000);
    wait_idle();
    chk({24'h00_0000, acc_o}, 32'h0000_0013);
    rd_chk(REG_PC_OFS, 32'h0000_0104);
    // Unmapped offset acks, reads zero, drops writes
    wr(8'h1C, 32'hFFFF_FFFF);
    rd_chk(8'h1C, 32'h0000_0000);
    // Byte lane select: only the high pointer byte is written
    wb_sel_i <= 4'h2;
    wr(REG_PTR_OFS, 32'h0000_AB00);
    wb_sel_i <= 4'hF;
    rd_chk(REG_PTR_OFS, 32'h0000_AB45);
    end_sim();
  end
endmodule
`default_nettype wire
